// *** inc/ata_cmd_pkg.sv ***
// constants for the taskfile command interpreter
`default_nettype none
package ata_cmd_pkg;
    // taskfile offsets, command block
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_ERROR = 3'h1;
    localparam logic [2:0] OFF_SCOUNT = 3'h2;
    localparam logic [2:0] OFF_SNUM = 3'h3;
    localparam logic [2:0] OFF_CYL_LO = 3'h4;
    localparam logic [2:0] OFF_CYL_HI = 3'h5;
    localparam logic [2:0] OFF_DEVHEAD = 3'h6;
    localparam logic [2:0] OFF_STATUS = 3'h7;
    // control block
    localparam logic [2:0] OFF_DEVCTL = 3'h6;
    // opcodes
    localparam logic [7:0] OP_NATIVE_MAX_EXT = 8'h27;
    localparam logic [7:0] OP_READ_SECT = 8'h20;
    localparam logic [7:0] OP_READ_SECT_MASK = 8'hfe;
    // field positions
    localparam int DEVCTL_HOB_BIT = 7;
    localparam int DH_LBA_BIT = 6;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_UNC = 6;
    localparam int ER_ABT = 2;
    // counts and reset values
    localparam logic [7:0] WORDS_LAST = 8'hff;
    localparam logic [8:0] COUNT_ZERO_MEANS = 9'h100;
    localparam logic [7:0] TF_RESET = 8'h00;
    localparam logic [7:0] SNUM_RESET = 8'h01;
endpackage
`default_nettype wire

// *** design/addr_step.sv ***
// next-sector address for chs or 28-bit lba
`timescale 1ns/1ps
`default_nettype none
module addr_step #(
    parameter logic [7:0] SECT_PER_TRACK = 8'h3f,
    parameter logic [3:0] HEAD_LAST = 4'hf
) (
    input wire logic lba_mode,
    input wire logic [7:0] snum,
    input wire logic [15:0] cyl,
    input wire logic [3:0] head,
    output logic [7:0] snum_next,
    output logic [15:0] cyl_next,
    output logic [3:0] head_next
);
    logic [27:0] lba_inc;

    always_comb begin
        lba_inc = {head, cyl, snum} + 28'h0000001;
        snum_next = snum;
        cyl_next = cyl;
        head_next = head;
        if (lba_mode) begin
            {head_next, cyl_next, snum_next} = lba_inc;
        end else if (snum < SECT_PER_TRACK) begin
            snum_next = snum + 8'h01;
        end else begin
            // chs sectors count from one
            snum_next = 8'h01;
            if (head < HEAD_LAST) begin
                head_next = head + 4'h1;
            end else begin
                head_next = 4'h0;
                cyl_next = cyl + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** design/ata_cmd.sv ***
// taskfile command interpreter: native max ext and read sectors
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - opcode 27h requests native maximum ext
// - answer true highest lba, ignore limits
// - hob selects low or high result bytes
// - opcodes 20h, 21h are read sectors
// - read sectors fetches media, feeds host
// - data moves as 16-bit words
// - uncorrectable sector stops the transfer
// - sector count zero means 256
// - sector number is chs sector or lba 7:0
// - cylinder bytes are cylinder or lba 23:8
// - head field is head or lba 27:24
// - retry bit ignored, both opcodes identical
// - sector count reports untransferred sectors
// - address registers end at last sector
module ata_cmd #(
    parameter logic [7:0] SECT_PER_TRACK = 8'h3f,
    parameter logic [3:0] HEAD_LAST = 4'hf
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ctl_sel,
    input wire logic [2:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    input wire logic [47:0] native_max,
    output logic media_req,
    output logic media_lba_mode,
    output logic [27:0] media_addr,
    input wire logic media_valid,
    output logic media_ready,
    input wire logic [15:0] media_word,
    input wire logic media_unc
);
    import ata_cmd_pkg::*;

    typedef enum {S_IDLE, S_REQ, S_WAIT, S_DRQ} state_t;

    state_t state_reg, state_next;
    logic [7:0] sc_reg, sc_next, sn_reg, sn_next, cl_reg, cl_next, ch_reg, ch_next;
    logic [7:0] dh_reg, dh_next, err_reg, err_next;
    logic [7:0] sn_hob_reg, sn_hob_next, cl_hob_reg, cl_hob_next, ch_hob_reg, ch_hob_next;
    logic [8:0] rem_reg, rem_next;
    logic [7:0] wcnt_reg, wcnt_next;
    logic [15:0] data_reg, data_next, rdata_reg, rdata_next;
    logic hob_reg, hob_next, errf_reg, errf_next;
    logic req_reg, req_next, mrdy_reg, mrdy_next;
    logic [7:0] st_snum;
    logic [15:0] st_cyl;
    logic [3:0] st_head;
    logic tf_wr, cmd_wr, data_rd;
    logic [7:0] status;

    assign tf_wr = wr && !ctl_sel && state_reg == S_IDLE;
    assign cmd_wr = tf_wr && addr == OFF_STATUS;
    assign data_rd = rd && !ctl_sel && addr == OFF_DATA;

    addr_step #(
        .SECT_PER_TRACK(SECT_PER_TRACK),
        .HEAD_LAST(HEAD_LAST)
    ) u_step (
        .lba_mode(dh_reg[DH_LBA_BIT]),
        .snum(sn_reg),
        .cyl({ch_reg, cl_reg}),
        .head(dh_reg[3:0]),
        .snum_next(st_snum),
        .cyl_next(st_cyl),
        .head_next(st_head)
    );

    ////////////////////////////////////////////////////////////////////////
    // status and register reads

    always_comb begin
        status = 8'h00;
        status[ST_BSY] = state_reg == S_REQ || state_reg == S_WAIT;
        status[ST_RDY] = 1'b1;
        status[ST_DSC] = 1'b1;
        status[ST_DRQ] = state_reg == S_DRQ;
        status[ST_ERR] = errf_reg;
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (rd && ctl_sel) begin
            rdata_next = {8'h00, status};
        end else if (rd) begin
            case (addr)
                OFF_DATA: rdata_next = data_reg;
                OFF_ERROR: rdata_next = {8'h00, err_reg};
                OFF_SCOUNT: rdata_next = {8'h00, sc_reg};
                OFF_SNUM: rdata_next = {8'h00, hob_reg ? sn_hob_reg : sn_reg};
                OFF_CYL_LO: rdata_next = {8'h00, hob_reg ? cl_hob_reg : cl_reg};
                OFF_CYL_HI: rdata_next = {8'h00, hob_reg ? ch_hob_reg : ch_reg};
                OFF_DEVHEAD: rdata_next = {8'h00, dh_reg};
                default: rdata_next = {8'h00, status};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencing

    always_comb begin
        state_next = state_reg;
        sc_next = sc_reg;
        sn_next = sn_reg;
        cl_next = cl_reg;
        ch_next = ch_reg;
        dh_next = dh_reg;
        err_next = err_reg;
        errf_next = errf_reg;
        sn_hob_next = sn_hob_reg;
        cl_hob_next = cl_hob_reg;
        ch_hob_next = ch_hob_reg;
        rem_next = rem_reg;
        wcnt_next = wcnt_reg;
        data_next = data_reg;
        hob_next = hob_reg;
        req_next = 1'b0;
        // taskfile writes outside idle (busy or drq) are dropped, the host must poll bsy and drq first
        if (wr && ctl_sel && addr == OFF_DEVCTL) begin
            hob_next = wdata[DEVCTL_HOB_BIT];
        end
        if (tf_wr) begin
            case (addr)
                OFF_SCOUNT: sc_next = wdata[7:0];
                OFF_SNUM: sn_next = wdata[7:0];
                OFF_CYL_LO: cl_next = wdata[7:0];
                OFF_CYL_HI: ch_next = wdata[7:0];
                OFF_DEVHEAD: dh_next = wdata[7:0];
                default: ;
            endcase
        end
        case (state_reg)
            S_IDLE: begin
                if (cmd_wr) begin
                    err_next = 8'h00;
                    errf_next = 1'b0;
                    if (wdata[7:0] == OP_NATIVE_MAX_EXT) begin
                        // straight from the drive geometry, never a set-max limit
                        {ch_next, cl_next, sn_next} = native_max[23:0];
                        {ch_hob_next, cl_hob_next, sn_hob_next} = native_max[47:24];
                    end else if ((wdata[7:0] & OP_READ_SECT_MASK) == OP_READ_SECT) begin
                        rem_next = (sc_reg == 8'h00) ? COUNT_ZERO_MEANS : {1'b0, sc_reg};
                        wcnt_next = 8'h00;
                        req_next = 1'b1;
                        state_next = S_REQ;
                    end else begin
                        err_next[ER_ABT] = 1'b1;
                        errf_next = 1'b1;
                    end
                end
            end
            S_REQ: state_next = S_WAIT;
            S_WAIT: begin
                if (media_unc) begin
                    // address stays on the failing sector, count keeps it as untransferred
                    err_next[ER_UNC] = 1'b1;
                    errf_next = 1'b1;
                    sc_next = rem_reg[7:0];
                    state_next = S_IDLE;
                end else if (media_valid) begin
                    data_next = media_word;
                    state_next = S_DRQ;
                end
            end
            S_DRQ: begin
                if (data_rd) begin
                    if (wcnt_reg == WORDS_LAST) begin
                        wcnt_next = 8'h00;
                        rem_next = rem_reg - 9'h001;
                        sc_next = rem_next[7:0];
                        if (rem_next == 9'h000) begin
                            state_next = S_IDLE;
                        end else begin
                            {sn_next, ch_next, cl_next, dh_next[3:0]} =
                                {st_snum, st_cyl, st_head};
                            req_next = 1'b1;
                            state_next = S_REQ;
                        end
                    end else begin
                        wcnt_next = wcnt_reg + 8'h01;
                        state_next = S_WAIT;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
        mrdy_next = state_next == S_WAIT;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            sc_reg <= SNUM_RESET;
            sn_reg <= SNUM_RESET;
            cl_reg <= TF_RESET;
            ch_reg <= TF_RESET;
            dh_reg <= TF_RESET;
            err_reg <= TF_RESET;
            errf_reg <= 1'b0;
            sn_hob_reg <= TF_RESET;
            cl_hob_reg <= TF_RESET;
            ch_hob_reg <= TF_RESET;
            rem_reg <= 9'h000;
            wcnt_reg <= 8'h00;
            data_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
            hob_reg <= 1'b0;
            req_reg <= 1'b0;
            mrdy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sc_reg <= sc_next;
            sn_reg <= sn_next;
            cl_reg <= cl_next;
            ch_reg <= ch_next;
            dh_reg <= dh_next;
            err_reg <= err_next;
            errf_reg <= errf_next;
            sn_hob_reg <= sn_hob_next;
            cl_hob_reg <= cl_hob_next;
            ch_hob_reg <= ch_hob_next;
            rem_reg <= rem_next;
            wcnt_reg <= wcnt_next;
            data_reg <= data_next;
            rdata_reg <= rdata_next;
            hob_reg <= hob_next;
            req_reg <= req_next;
            mrdy_reg <= mrdy_next;
        end
    end

    assign rdata = rdata_reg;
    assign media_req = req_reg;
    assign media_ready = mrdy_reg;
    assign media_lba_mode = dh_reg[DH_LBA_BIT];
    assign media_addr = {dh_reg[3:0], ch_reg, cl_reg, sn_reg};

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_native_low: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && wdata[7:0] == OP_NATIVE_MAX_EXT |=>
            {ch_reg, cl_reg, sn_reg} == $past(native_max[23:0]))
        else $error("native max low bytes wrong");
    a_hob_read: assert property (@(posedge mclk) disable iff (!rst_n)
        rd && !ctl_sel && addr == OFF_SNUM && hob_reg |=> rdata[7:0] == $past(sn_hob_reg))
        else $error("hob read of sector number wrong");
    a_count_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && wdata[7:1] == 7'h10 && sc_reg == 8'h00 |=> rem_reg == 9'h100)
        else $error("zero count not 256");
    a_read_start: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && wdata[7:1] == 7'h10 |=> media_req ##1 (!media_req && state_reg == S_WAIT))
        else $error("read sectors did not start");
    a_unc_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_WAIT && media_unc |=>
            state_reg == S_IDLE && err_reg[ER_UNC] && status[ST_ERR])
        else $error("transfer not stopped on uncorrectable");
    a_unc_left: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_WAIT && media_unc |=> sc_reg == $past(rem_reg[7:0]))
        else $error("untransferred count wrong");
    a_word_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_WAIT && media_valid && !media_unc |=>
            status[ST_DRQ] && data_reg == $past(media_word))
        else $error("media word not held for host");
    a_done_clean: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == S_DRQ && data_rd && wcnt_reg == WORDS_LAST && rem_reg == 9'h001 |=>
            state_reg == S_IDLE && sc_reg == 8'h00 && $stable(media_addr))
        else $error("final sector end state wrong");
    a_ready_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        media_ready == (state_reg == S_WAIT))
        else $error("media ready out of step");
endmodule
`default_nettype wire

// *** bench/ata_host_model.sv ***
// host controller model: taskfile register cycles
`timescale 1ns/1ps
`default_nettype none
module ata_host_model (
    input wire logic mclk,
    output logic ctl_sel,
    output logic [2:0] addr,
    output logic wr,
    output logic rd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    import ata_cmd_pkg::*;
    initial begin
        {ctl_sel, addr, wr, rd, wdata} = '0;
    end
    ////////////////////////////////////////
    task automatic wr_reg(input logic c, input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        {ctl_sel, addr, wdata, wr} <= {c, a, 8'h00, d, 1'b1};
        @(posedge mclk);
        wr <= 1'b0;
        // released bus never shows the old value
        wdata <= {8'h00, ~d};
    endtask
    // one data-register read takes exactly one word
    task automatic rd_reg(input logic c, input logic [2:0] a, output logic [15:0] v);
        @(posedge mclk);
        {ctl_sel, addr, rd} <= {c, a, 1'b1};
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic issue(input logic [7:0] op);
        wr_reg(1'b0, OFF_STATUS, op);
    endtask
    // upper result bytes show only after the selector is set
    task automatic set_hob(input logic h);
        wr_reg(1'b1, OFF_DEVCTL, {h, 7'h00});
    endtask
endmodule
`default_nettype wire

// *** bench/ata_read_sector_native_max_test.sv ***
// self-checking bench: native max query and sector reads
`timescale 1ns/1ps
`default_nettype none
module ata_read_sector_native_max_test;
    import ata_cmd_pkg::*;
    localparam logic [7:0] SPT = 8'h3f;
    localparam logic [3:0] HLAST = 4'hf;
    logic mclk, rst_n, ctl_sel, wr, rd, media_req, media_lba_mode, media_valid, media_ready;
    logic media_unc, cur_lba;
    logic [2:0] addr;
    logic [15:0] wdata, rdata, media_word, v;
    logic [47:0] native_max;
    logic [27:0] media_addr, cur_addr;
    logic [27:0] req_q[$];
    int bad_count, comparisons, sect_idx, word_idx, k;
    int unc_at = -1;
    ata_cmd #(.SECT_PER_TRACK(SPT), .HEAD_LAST(HLAST)) DUT (
        .mclk(mclk), .rst_n(rst_n), .ctl_sel(ctl_sel), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata), .native_max(native_max), .media_req(media_req),
        .media_lba_mode(media_lba_mode), .media_addr(media_addr), .media_valid(media_valid),
        .media_ready(media_ready), .media_word(media_word), .media_unc(media_unc));
    ata_host_model host (.mclk(mclk), .ctl_sel(ctl_sel), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata), .rdata(rdata));
    ////////////////////////////////////////
    function automatic logic [15:0] word_of(logic [27:0] a, int i);
        return {a[7:0] ^ a[15:8] ^ a[23:16] ^ {4'h0, a[27:24]}, i[7:0]};
    endfunction
    // stalled media shows the inverse, so a stale word cannot pass
    assign media_word = media_valid ? word_of(cur_addr, word_idx) : ~word_of(cur_addr, word_idx);
    assign media_unc = (sect_idx == unc_at);
    // one process owns the media side, reset included
    always @(posedge mclk) begin
        if (!rst_n) begin
            media_valid <= 1'b0;
            cur_addr <= 28'h0000000;
            cur_lba <= 1'b0;
        end else begin
            media_valid <= ($urandom % 4) != 0;
            if (media_req) begin
                req_q.push_back(media_addr);
                cur_addr <= media_addr;
                cur_lba <= media_lba_mode;
                sect_idx <= sect_idx + 1;
                word_idx <= 0;
            end else if (media_valid && media_ready) begin
                word_idx <= word_idx + 1;
            end
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_idle(output logic [15:0] st);
        for (int i = 0; i < 400; i++) begin
            host.rd_reg(1'b1, 3'h7, st);
            if (st[ST_BSY] === 1'b0) return;
        end
        bad_count++;
        results();
    endtask
    function automatic logic [27:0] next_addr(logic lba, logic [27:0] a);
        if (lba) return a + 28'h1;
        if (a[7:0] < SPT) return {a[27:8], a[7:0] + 8'h01};
        if (a[27:24] < HLAST) return {a[27:24] + 4'h1, a[23:8], 8'h01};
        return {4'h0, a[23:8] + 16'h0001, 8'h01};
    endfunction
    task automatic run_read(input logic [7:0] op, input logic lba, input logic [7:0] cnt,
                            input logic [27:0] start, input int unc_sect);
        logic [27:0] a;
        logic [15:0] st;
        int n, s, w, qb;
        n = (cnt == 8'h00) ? 256 : int'(cnt);
        a = start;
        unc_at = (unc_sect == 0) ? -1 : sect_idx + unc_sect;
        qb = req_q.size();
        for (w = 0; w < 3; w++) host.wr_reg(1'b0, OFF_SNUM + 3'(w), start[8*w +: 8]);
        host.wr_reg(1'b0, OFF_DEVHEAD, {1'b1, lba, 2'b10, start[27:24]});
        host.wr_reg(1'b0, OFF_SCOUNT, cnt);
        host.issue(op);
        for (s = 1; s <= n; s++) begin
            wait_idle(st);
            check({4'h0, req_q[qb + s - 1]}, {4'h0, a});
            if (s == unc_sect) break;
            check(st, 16'h0058);
            for (w = 0; w < 256; w++) begin
                if (w > 0) wait_idle(st);
                host.rd_reg(1'b0, OFF_DATA, st);
                check(st, word_of(a, w));
            end
            if (s < n) a = next_addr(lba, a);
        end
        wait_idle(st);
        check(st, (unc_sect != 0) ? 16'h0051 : 16'h0050);
        host.rd_reg(1'b0, OFF_ERROR, st);
        check(st, (unc_sect != 0) ? 16'h0040 : 16'h0000);
        host.rd_reg(1'b0, OFF_SCOUNT, st);
        check(st, {8'h00, 8'(n - s + 1)});
        for (w = 0; w < 3; w++) begin
            host.rd_reg(1'b0, OFF_SNUM + 3'(w), st);
            check(st, {8'h00, a[8*w +: 8]});
        end
        host.rd_reg(1'b0, OFF_DEVHEAD, st);
        check({28'h0, st[3:0]}, {28'h0, a[27:24]});
        check({31'h0, cur_lba}, {31'h0, lba});
    endtask
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        rst_n = 1'b0;
        native_max = 48'h0;
        void'($urandom(29755));
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        host.rd_reg(1'b1, 3'h7, v);
        check(v, 16'h0050);
        host.rd_reg(1'b0, OFF_SCOUNT, v);
        check(v, 16'h0001);
        host.issue(8'hc3);
        host.rd_reg(1'b0, OFF_ERROR, v);
        check(v, 16'h0004);
        @(posedge mclk) native_max <= 48'({$urandom, $urandom});
        // preset sector number: the answer must overwrite it
        host.wr_reg(1'b0, OFF_SNUM, 8'h5a);
        host.issue(8'h27);
        for (k = 0; k < 6; k++) begin
            if (k == 3) host.set_hob(1'b1);
            host.rd_reg(1'b0, OFF_SNUM + 3'(k % 3), v);
            check(v, {8'h00, native_max[8*k +: 8]});
        end
        host.set_hob(1'b0);
        run_read(8'h20, 1'b1, 8'h02, {4'($urandom), 24'($urandom)}, 0);
        run_read(8'h21, 1'b0, 8'h02, {4'h3, 16'($urandom), SPT}, 0);
        run_read(8'h20, 1'b0, 8'h02, {HLAST, 16'($urandom), SPT}, 0);
        run_read(8'h21, 1'b1, 8'h03, {4'($urandom), 24'($urandom)}, 2);
        run_read(8'h20, 1'b1, 8'h00, {4'($urandom), 24'($urandom)}, 2);
        results();
    end
endmodule
`default_nettype wire
